//--- verilog/mlsc_defs.svh
// memory map, host register map and timing constants of the module low-speed control
`ifndef MLSC_DEFS_SVH
`define MLSC_DEFS_SVH
// -------------------------------------------------------------------------
// module memory map (byte offsets on the 2-wire bus)
// -------------------------------------------------------------------------
`define MLSC_DEV_ADDR      7'h50
`define MLSC_OFF_STATUS    8'h02
`define MLSC_OFF_FLAGS     8'h03
`define MLSC_OFF_LANE      8'h04
`define MLSC_OFF_MASK      8'h05
`define MLSC_STAT_PEND_BIT 0
`define MLSC_STAT_LP_BIT   1
`define MLSC_FLAG_DONE_BIT 0
`define MLSC_FLAG_LANE_POS 4
`define MLSC_FLAGS_RST     8'h00
`define MLSC_LANE_RST      8'h00
`define MLSC_MASK_RST      8'h00
// -------------------------------------------------------------------------
// host register map (avalon byte addresses) and fields
// -------------------------------------------------------------------------
`define MLSC_AV_CTRL       8'h00
`define MLSC_AV_CMD        8'h04
`define MLSC_AV_STAT       8'h08
`define MLSC_AV_IRQ        8'h0c
`define MLSC_AV_MASK       8'h10
`define MLSC_CTRL_SEL_BIT  0
`define MLSC_CTRL_RST_BIT  1
`define MLSC_CTRL_LP_BIT   2
`define MLSC_CMD_RD_BIT    16
`define MLSC_IRQ_DONE_BIT  0
`define MLSC_IRQ_ATTN_BIT  1
`define MLSC_IRQ_PRES_BIT  2
`define MLSC_CTRL_RST      3'h0
// -------------------------------------------------------------------------
// timing
// -------------------------------------------------------------------------
`define MLSC_CLK_MHZ       250
`define MLSC_INIT_MS       2000
`define MLSC_INIT_CYC      (`MLSC_INIT_MS * 1000 * `MLSC_CLK_MHZ)
`define MLSC_MIN_RST_US    10
`define MLSC_MIN_RST_CYC   (`MLSC_MIN_RST_US * `MLSC_CLK_MHZ)
`define MLSC_SCL_QTR_NS    625
`define MLSC_SCL_QTR_CYC   ((`MLSC_SCL_QTR_NS * `MLSC_CLK_MHZ) / 1000)
`endif

//--- verilog/mlsc_pkg.sv
// state types shared by both ends of the module low-speed control
package mlsc_pkg;
  // 2-wire slave phase inside the module
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_OFFS, SL_WR, SL_RD} mlsc_slv_type;
  // 2-wire master phase inside the host
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} mlsc_mst_type;
endpackage : mlsc_pkg

//--- verilog/mlsc_if.sv
// pins between host board and module, with open-drain resolution
`timescale 1ns/10ps
interface mlsc_if;
  logic module_select_n;   // host -> module select
  logic module_reset_n;    // host -> module reset
  logic low_power_select;  // host -> module power limit
  logic scl_o;             // host clock drive value
  logic scl_oe;            // host clock drive enable
  logic sda_h_o;           // host data drive value
  logic sda_h_oe;          // host data drive enable
  logic sda_d_o;           // module data drive value
  logic sda_d_oe;          // module data drive enable
  logic attn_o;            // module attention drive value
  logic attn_oe;           // module attention drive enable
  logic pres_o;            // module presence drive value
  logic pres_oe;           // module presence drive enable
  logic scl;               // resolved clock line
  logic sda;               // resolved data line
  logic attention_n;       // resolved attention line
  logic module_present_n;  // resolved presence line
  // pull-ups win unless some enabled driver pulls low
  assign scl              = ~(scl_oe & ~scl_o);
  assign sda              = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
  assign attention_n      = ~(attn_oe & ~attn_o);
  assign module_present_n = ~(pres_oe & ~pres_o);
  modport host (output module_select_n, module_reset_n, low_power_select, scl_o, scl_oe,
                sda_h_o, sda_h_oe, input scl, sda, attention_n, module_present_n);
  modport dev (input module_select_n, module_reset_n, low_power_select, scl, sda,
               output sda_d_o, sda_d_oe, attn_o, attn_oe, pres_o, pres_oe);
endinterface : mlsc_if

//--- verilog/mlsc_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module mlsc_sync #(
  parameter int          W    = 1,  // bits synchronised
  parameter logic [W-1:0] INIT = '1  // value under reset (idle pull-up)
) (
  input  wire logic         ref_clk, // core clock
  input  wire logic         rst,     // async reset, high
  input  wire logic [W-1:0] async_i, // pin levels
  output logic      [W-1:0] sync_o   // synchronised levels
);
  logic [W-1:0] meta_q;
  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= INIT;
      sync_o <= INIT;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : mlsc_sync

//--- verilog/mlsc_module_end.sv
// module-side low-speed control: 2-wire slave, reset, init, attention, presence
//
// The Avalon-MM slave port of the host end and its register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "mlsc_defs.svh"
// Functional notes
// - answer bus only while select is low
// - host gives each module own select
// - 2-wire bus reads and writes memory map
// - long reset pulse restores all defaults
// - host ignores status until reset completes
// - reset end raises attention, clears pending
// - power-up posts same completion attention
// - low-power input limits module power
// - presence pin pulled low when inserted
// - attention low flags fault or status
// - host reads memory map to find source
// - attention only pulled low, host pulls up
// - lanes addressed singly, unused shut down
// - fully functional within 2000 ms
module mlsc_module_end #(
  parameter int INIT_CYC    = `MLSC_INIT_CYC,    // power-on initialisation cycles
  parameter int MIN_RST_CYC = `MLSC_MIN_RST_CYC, // shortest reset pulse in cycles
  parameter int LANES       = 4                  // number of lanes
) (
  input  wire logic             ref_clk,       // core clock
  input  wire logic             rst,           // power-up reset, high
  mlsc_if.dev                   link,          // pins toward the host
  input  wire logic [LANES-1:0] lane_fault,    // lane fault pulses
  output logic      [LANES-1:0] lane_disable,  // lane shut-down controls
  output logic                  high_power_en, // high power allowed
  output logic                  init_pending   // initialisation in progress
);
  import mlsc_pkg::*;

  // -----------------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------------
  if (INIT_CYC < 1 || MIN_RST_CYC < 1 || LANES < 1 || LANES > 4)
  begin : g_bad_param
    $error("mlsc_module_end: unsupported parameter value");
  end

  // -----------------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------------
  logic       scl_s, sda_s, sel_n_s, rst_n_s, lp_s;
  logic [4:0] pins_s;
  mlsc_sync #(.W(5), .INIT(5'h1f)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .async_i ({link.scl, link.sda, link.module_select_n, link.module_reset_n,
               link.low_power_select}),
    .sync_o  (pins_s)
  );
  assign {scl_s, sda_s, sel_n_s, rst_n_s, lp_s} = pins_s;

  // -----------------------------------------------------------------------
  // reset pulse qualification and initialisation timer
  // -----------------------------------------------------------------------
  logic [31:0] low_cnt_q;
  logic [31:0] init_cnt_q;
  logic        init_q;
  logic        mod_rst;
  logic        done_evt;

  // short glitches never reach the saturation value
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      low_cnt_q <= 32'h0;
    else if (rst_n_s)
      low_cnt_q <= 32'h0;
    else if (low_cnt_q != 32'(MIN_RST_CYC))
      low_cnt_q <= low_cnt_q + 32'h1;
  end
  assign mod_rst = (low_cnt_q == 32'(MIN_RST_CYC));

  // pending from power-up or qualified reset until the timer runs out
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      init_q     <= 1'b1;
      init_cnt_q <= 32'h0;
    end
    else if (mod_rst)
    begin
      init_q     <= 1'b1;
      init_cnt_q <= 32'h0;
    end
    else if (done_evt)
      init_q <= 1'b0;
    else if (init_q)
      init_cnt_q <= init_cnt_q + 32'h1;
  end
  assign done_evt = init_q & ~mod_rst & (init_cnt_q == 32'(INIT_CYC - 1));

  // -----------------------------------------------------------------------
  // 2-wire slave
  // -----------------------------------------------------------------------
  mlsc_slv_type st_q;
  logic        scl_p_q, sda_p_q;
  logic [3:0]  bcnt_q;
  logic [7:0]  shift_q, tx_q, ptr_q, rd_data;
  logic        ack_q;
  logic        live, rise, fall, start, stop, byte_end, ack_end, wr_stb, ld_stb;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // deselected or resetting modules see no bus at all
  assign live     = ~sel_n_s & ~mod_rst;
  assign rise     = scl_s & ~scl_p_q;
  assign fall     = ~scl_s & scl_p_q;
  assign start    = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop     = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign byte_end = live & fall & (st_q != SL_IDLE) & (bcnt_q == 4'd7);
  assign ack_end  = live & fall & (st_q != SL_IDLE) & (bcnt_q == 4'd8);
  assign wr_stb   = byte_end & (st_q == SL_WR);
  assign ld_stb   = ack_end & (st_q == SL_RD);

  // protocol walk: address, offset, then write data or read data
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q    <= SL_IDLE;
      bcnt_q  <= 4'h0;
      ack_q   <= 1'b0;
      ptr_q   <= 8'h00;
      tx_q    <= 8'h00;
      shift_q <= 8'h00;
    end
    else if (!live || stop)
    begin
      st_q   <= SL_IDLE;
      bcnt_q <= 4'h0;
      ack_q  <= 1'b0;
    end
    else if (start)
    begin
      st_q   <= SL_ADDR;
      bcnt_q <= 4'hf; // the fall that closes the start wraps this to zero
      ack_q  <= 1'b0;
    end
    else
    begin
      if (rise && bcnt_q < 4'd8)
        shift_q <= {shift_q[6:0], sda_s};
      // host nack after read data ends the transfer
      if (rise && bcnt_q == 4'd8 && st_q == SL_RD && sda_s)
        st_q <= SL_IDLE;
      if (byte_end)
      begin
        bcnt_q <= 4'd8;
        unique case (st_q)
          SL_ADDR:
          begin
            if (shift_q[7:1] == `MLSC_DEV_ADDR)
            begin
              ack_q <= 1'b1;
              st_q  <= shift_q[0] ? SL_RD : SL_OFFS;
            end
            else
              st_q <= SL_IDLE;
          end
          SL_OFFS:
          begin
            ptr_q <= shift_q;
            ack_q <= 1'b1;
            st_q  <= SL_WR;
          end
          SL_WR:
          begin
            ptr_q <= ptr_q + 8'h01;
            ack_q <= 1'b1;
          end
          SL_RD, SL_IDLE: ;
        endcase
      end
      else if (ack_end)
      begin
        bcnt_q <= 4'h0;
        ack_q  <= 1'b0;
        if (ld_stb)
        begin
          tx_q  <= rd_data;
          ptr_q <= ptr_q + 8'h01;
        end
      end
      else if (fall && st_q != SL_IDLE)
      begin
        bcnt_q <= bcnt_q + 4'h1;
        tx_q   <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // data line only ever pulled low
  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = ack_q | ((st_q == SL_RD) & (bcnt_q < 4'd8) & ~tx_q[7]);

  // -----------------------------------------------------------------------
  // memory map
  // -----------------------------------------------------------------------
  logic [7:0] flags_q, mask_q, lane_q, flag_set, flag_clr;
  logic       attn_q, hp_q;

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rd_data = 8'h00;
    unique case (ptr_q)
      `MLSC_OFF_STATUS:
      begin
        rd_data[`MLSC_STAT_PEND_BIT] = init_q;
        rd_data[`MLSC_STAT_LP_BIT]   = lp_s;
      end
      `MLSC_OFF_FLAGS: rd_data = flags_q;
      `MLSC_OFF_LANE:  rd_data = lane_q;
      `MLSC_OFF_MASK:  rd_data = mask_q;
      default:         rd_data = 8'h00;
    endcase
  end

  // writable settings fall back to defaults on any reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lane_q <= `MLSC_LANE_RST;
      mask_q <= `MLSC_MASK_RST;
    end
    else if (mod_rst)
    begin
      lane_q <= `MLSC_LANE_RST;
      mask_q <= `MLSC_MASK_RST;
    end
    else if (wr_stb && ptr_q == `MLSC_OFF_LANE)
      lane_q <= shift_q;
    else if (wr_stb && ptr_q == `MLSC_OFF_MASK)
      mask_q <= shift_q;
  end

  // flags clear on read; a new event in the same cycle survives
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[`MLSC_FLAG_DONE_BIT] = done_evt;
    flag_set[`MLSC_FLAG_LANE_POS +: LANES] = lane_fault;
    flag_clr = (ld_stb && ptr_q == `MLSC_OFF_FLAGS) ? flags_q : 8'h00;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      flags_q <= `MLSC_FLAGS_RST;
    else if (mod_rst)
      flags_q <= `MLSC_FLAGS_RST;
    else
      flags_q <= (flags_q & ~flag_clr) | flag_set;
  end

  // registered pin and user outputs
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      attn_q <= 1'b0;
      hp_q   <= 1'b0;
    end
    else
    begin
      attn_q <= |(flags_q & ~mask_q);
      hp_q   <= ~lp_s & ~init_q & ~mod_rst;
    end
  end

  assign link.attn_o   = 1'b0;
  assign link.attn_oe  = attn_q;
  assign link.pres_o   = 1'b0;
  assign link.pres_oe  = 1'b1;
  assign lane_disable  = lane_q[LANES-1:0];
  assign high_power_en = hp_q;
  assign init_pending  = init_q;
endmodule : mlsc_module_end

//--- verilog/mlsc_host_end.sv
// host-side control: avalon registers, module pins, 2-wire master
`timescale 1ns/10ps
`include "mlsc_defs.svh"
module mlsc_host_end #(
  parameter int QTR_CYC = `MLSC_SCL_QTR_CYC // cycles per quarter serial bit
) (
  input  wire logic        ref_clk,         // core clock
  input  wire logic        rst,             // async reset, high
  mlsc_if.host             link,            // pins toward the module
  input  wire logic [7:0]  avs_address,     // byte address
  input  wire logic        avs_read,        // read request
  input  wire logic        avs_write,       // write request
  input  wire logic [31:0] avs_writedata,   // write data
  output logic      [31:0] avs_readdata,    // read data
  output logic             avs_waitrequest, // stall
  output logic             irq              // level interrupt
);
  import mlsc_pkg::*;

  if (QTR_CYC < 1 || QTR_CYC > 65535)
  begin : g_bad_param
    $error("mlsc_host_end: unsupported QTR_CYC");
  end

  // -----------------------------------------------------------------------
  // avalon slave: one wait cycle, then accept
  // -----------------------------------------------------------------------
  logic [2:0] ctrl_q, irq_q, mask_q, irq_set;
  logic [7:0] off_q, wdat_q, rdat_q;
  logic       rd_q, nack_q, ack_q, acc, go;
  logic       sda_s, attn_s, pres_s, attn_p_q, pres_p_q;
  mlsc_mst_type st_q;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign acc             = (avs_read | avs_write) & ack_q;
  assign go = acc & avs_write & (avs_address == `MLSC_AV_CMD) & (st_q == MS_IDLE);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      // data settles in the wait cycle and stands at the accept edge
      unique case (avs_address)
        `MLSC_AV_CTRL: avs_readdata <= {29'h0, ctrl_q};
        `MLSC_AV_CMD:  avs_readdata <= {15'h0, rd_q, off_q, wdat_q};
        `MLSC_AV_STAT: avs_readdata <= {16'h0, rdat_q, 4'h0, ~attn_s, ~pres_s, nack_q,
                                        st_q != MS_IDLE};
        `MLSC_AV_IRQ:  avs_readdata <= {29'h0, irq_q};
        `MLSC_AV_MASK: avs_readdata <= {29'h0, mask_q};
        default:       avs_readdata <= 32'h0;
      endcase
    end
  end

  // control, command and mask registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `MLSC_CTRL_RST;
      mask_q <= 3'h0;
      off_q  <= 8'h00;
      wdat_q <= 8'h00;
      rd_q   <= 1'b0;
    end
    else if (acc && avs_write && avs_address == `MLSC_AV_CTRL)
      ctrl_q <= avs_writedata[2:0];
    else if (acc && avs_write && avs_address == `MLSC_AV_MASK)
      mask_q <= avs_writedata[2:0];
    else if (go)
    begin
      wdat_q <= avs_writedata[7:0];
      off_q  <= avs_writedata[15:8];
      rd_q   <= avs_writedata[`MLSC_CMD_RD_BIT];
    end
  end

  // one select per module; reset and power limit straight from control
  assign link.module_select_n  = ~ctrl_q[`MLSC_CTRL_SEL_BIT];
  assign link.module_reset_n   = ~ctrl_q[`MLSC_CTRL_RST_BIT];
  assign link.low_power_select = ctrl_q[`MLSC_CTRL_LP_BIT];

  // -----------------------------------------------------------------------
  // pin inputs and interrupt status
  // -----------------------------------------------------------------------
  mlsc_sync #(.W(3), .INIT(3'h7)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .async_i ({link.sda, link.attention_n, link.module_present_n}),
    .sync_o  ({sda_s, attn_s, pres_s})
  );

  logic [15:0] qcnt_q;
  logic [1:0]  q_q;
  logic [3:0]  bi_q;
  logic [1:0]  k_q;
  logic        tick, last, scl_c, sda_c, scl_q, sda_q;
  logic [7:0]  txb;

  always_comb
  begin
    irq_set = 3'h0;
    irq_set[`MLSC_IRQ_DONE_BIT] = (st_q == MS_STOP) & tick & (q_q == 2'd3);
    irq_set[`MLSC_IRQ_ATTN_BIT] = attn_p_q & ~attn_s;
    irq_set[`MLSC_IRQ_PRES_BIT] = pres_p_q ^ pres_s;
  end

  // write-one-to-clear; a set in the same cycle wins
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_q    <= 3'h0;
      attn_p_q <= 1'b1;
      pres_p_q <= 1'b1;
    end
    else
    begin
      attn_p_q <= attn_s;
      pres_p_q <= pres_s;
      irq_q    <= (irq_q & ~((acc && avs_write && avs_address == `MLSC_AV_IRQ) ?
                  avs_writedata[2:0] : 3'h0)) | irq_set;
    end
  end
  assign irq = |(irq_q & mask_q);

  // -----------------------------------------------------------------------
  // 2-wire master: quarter-bit ticks, bytes addr-w, offset, data or
  // repeated start, addr-r, read data with nack
  // -----------------------------------------------------------------------
  assign tick = (qcnt_q == 16'(QTR_CYC - 1));
  assign last = rd_q ? (k_q == 2'd3) : (k_q == 2'd2);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      qcnt_q <= 16'h0;
    else
      qcnt_q <= tick ? 16'h0 : qcnt_q + 16'h1;
  end

  always_comb
  begin
    unique case (k_q)
      2'd0: txb = {`MLSC_DEV_ADDR, 1'b0};
      2'd1: txb = off_q;
      2'd2: txb = rd_q ? {`MLSC_DEV_ADDR, 1'b1} : wdat_q;
      2'd3: txb = 8'hff;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q   <= MS_IDLE;
      q_q    <= 2'd0;
      bi_q   <= 4'h0;
      k_q    <= 2'd0;
      nack_q <= 1'b0;
      rdat_q <= 8'h00;
    end
    else
    begin
      unique case (st_q)
        MS_IDLE:
        begin
          if (go)
          begin
            st_q   <= MS_START;
            q_q    <= 2'd0;
            k_q    <= 2'd0;
            nack_q <= 1'b0;
          end
        end
        MS_START:
        begin
          if (tick)
          begin
            q_q  <= q_q + 2'd1;
            bi_q <= 4'h0;
            if (q_q == 2'd3)
              st_q <= MS_BIT;
          end
        end
        MS_BIT:
        begin
          if (tick)
          begin
            q_q <= q_q + 2'd1;
            if (q_q == 2'd2 && bi_q < 4'd8 && k_q == 2'd3)
              rdat_q <= {rdat_q[6:0], sda_s};
            if (q_q == 2'd2 && bi_q == 4'd8 && k_q != 2'd3 && sda_s)
              nack_q <= 1'b1;
            if (q_q == 2'd3 && bi_q != 4'd8)
              bi_q <= bi_q + 4'h1;
            else if (q_q == 2'd3)
            begin
              bi_q <= 4'h0;
              if (nack_q || last)
                st_q <= MS_STOP;
              else if (rd_q && k_q == 2'd1)
                st_q <= MS_START;
              k_q <= k_q + 2'd1;
            end
          end
        end
        MS_STOP:
        begin
          if (tick)
          begin
            q_q <= q_q + 2'd1;
            if (q_q == 2'd3)
              st_q <= MS_IDLE;
          end
        end
      endcase
    end
  end

  // line levels per quarter
  always_comb
  begin
    scl_c = 1'b1;
    sda_c = 1'b1;
    unique case (st_q)
      MS_IDLE: ;
      MS_START:
      begin
        scl_c = (q_q == 2'd1) | (q_q == 2'd2);
        sda_c = ~q_q[1];
      end
      MS_BIT:
      begin
        scl_c = (q_q == 2'd1) | (q_q == 2'd2);
        sda_c = (bi_q < 4'd8) ? txb[3'd7 - bi_q[2:0]] : 1'b1;
      end
      MS_STOP:
      begin
        scl_c = (q_q != 2'd0);
        sda_c = q_q[1];
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_c;
      sda_q <= sda_c;
    end
  end

  // open-drain: enable only to pull low
  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = ~scl_q;
  assign link.sda_h_o  = 1'b0;
  assign link.sda_h_oe = ~sda_q;
endmodule : mlsc_host_end

//--- verification/mlsc_chk.sv
// pin-level assertions between host board and module
`timescale 1ns/10ps
module mlsc_chk (
  input wire logic ref_clk,          // core clock
  input wire logic rst,              // async reset, high
  input wire logic module_select_n,  // select pin
  input wire logic module_reset_n,   // reset pin
  input wire logic scl,              // serial clock line
  input wire logic sda_d_oe,         // module data enable
  input wire logic attn_o,           // attention drive value
  input wire logic attn_oe,          // attention drive enable
  input wire logic attention_n,      // resolved attention line
  input wire logic module_present_n  // resolved presence line
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // long low pulse on the reset pin, then its release
  sequence long_rst;
    !module_reset_n [*8] ##1 module_reset_n;
  endsequence
  // reset pin still held well past the sync lag
  sequence held_rst;
    !module_reset_n [*8] ##1 !module_reset_n [*8];
  endsequence
  chk_attn_drain: assert property (attn_oe |-> !attn_o)
    else $error("attention driven high");
  chk_present_low: assert property (!module_present_n)
    else $error("presence line high");
  chk_desel_quiet: assert property (module_select_n [*8] |-> !sda_d_oe)
    else $error("answer while deselected");
  chk_rst_mute: assert property (held_rst |-> !sda_d_oe)
    else $error("answer while in reset");
  chk_rst_clear: assert property (held_rst |-> attention_n)
    else $error("flags kept through reset");
  chk_rst_quiet: assert property (long_rst |-> attention_n [*8])
    else $error("attention during init");
  chk_rst_done: assert property (long_rst |-> ##[150:400] !attention_n)
    else $error("no completion after reset");
  chk_power_done: assert property ($fell(rst) |-> ##[150:400] !attention_n)
    else $error("no completion after power-up");
  // data only moves while the clock is low, so no false start or stop
  chk_sda_low: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("data moved with clock high");
endmodule : mlsc_chk

//--- verification/module_low_speed_control_tb.sv
// self-checking bench joining host end and module end
`timescale 1ns/10ps
`define CMP(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s exp %h seen %h", n, e, s); end end
module module_low_speed_control_tb;
  logic        ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, seed = 32'hf323b7f2, d, avs_readdata;
  logic [3:0]  lane_fault = 4'h0, v, lane_disable;
  logic        avs_waitrequest, irq, high_power_en, init_pending;
  logic [31:0] exp_q[$], msk_q[$];
  int          failures = 0, num_checks = 0;
  mlsc_if link ();
  mlsc_host_end #(.QTR_CYC(8)) mlsc_host_end_i (.ref_clk, .rst, .link(link.host),
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .irq);
  mlsc_module_end #(.INIT_CYC(200), .MIN_RST_CYC(8)) mlsc_module_end_i (.ref_clk,
    .rst, .link(link.dev), .lane_fault, .lane_disable, .high_power_en, .init_pending);
  mlsc_chk mlsc_chk_i (.ref_clk, .rst, .module_select_n(link.module_select_n),
    .module_reset_n(link.module_reset_n), .scl(link.scl), .sda_d_oe(link.sda_d_oe),
    .attn_o(link.attn_o), .attn_oe(link.attn_oe), .attention_n(link.attention_n),
    .module_present_n(link.module_present_n));
  // 250 MHz core clock
  always #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // one avalon cycle, held until waitrequest is sampled low at a rising edge;
  // only reads note an expectation, e under mask m
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] w, e, m);
    @(posedge ref_clk);
    if (!wr)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= w;
    @(posedge ref_clk);
    for (int n = 0; n < 50 && avs_waitrequest !== 1'b0; n++)
      @(posedge ref_clk);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      conclude();
    end
  endtask : bus
  // start a 2-wire transfer and poll busy under a bound
  task automatic cmd(input logic [31:0] w);
    bus(1, 8'h04, w, 0, 0);
    d = 32'h1;
    for (int n = 0; n < 2000 && d[0] !== 1'b0; n++)
      bus(0, 8'h08, 0, 0, 0);
    if (d[0] !== 1'b0)
    begin
      failures++;
      conclude();
    end
  endtask : cmd
  // compare each accepted read that has a nonzero mask with the oldest note
  always @(negedge ref_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && msk_q.size() > 0)
    begin
      if (msk_q[0] != 0) `CMP("readdata", exp_q[0], avs_readdata & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (300) @(posedge ref_clk);
    `CMP("irq", 1'b0, irq)
    bus(1, 8'h10, 2, 0, 0);
    bus(0, 8'h0c, 0, 2, 2);
    @(negedge ref_clk);
    `CMP("irq", 1'b1, irq)
    bus(1, 8'h0c, 7, 0, 0);
    @(negedge ref_clk);
    `CMP("irq", 1'b0, irq)
    $display("power-up test done");
    seed = lfsr(seed);
    v = seed[3:0];
    bus(1, 8'h00, 1, 0, 0);
    cmd(32'h400 | v);
    `CMP("lanes", v, lane_disable)
    cmd(32'h10400);
    bus(0, 8'h08, 0, {20'h0, v, 8'h00}, 32'hff02);
    bus(1, 8'h00, 0, 0, 0);
    cmd(32'h400);
    bus(0, 8'h08, 0, 2, 2);
    $display("bus test done");
    bus(1, 8'h00, 5, 0, 0);
    repeat (10) @(negedge ref_clk);
    `CMP("power", 1'b0, high_power_en)
    bus(1, 8'h00, 3, 0, 0);
    bus(1, 8'h00, 1, 0, 0);
    repeat (20) @(negedge ref_clk);
    `CMP("power", 1'b1, high_power_en)
    `CMP("lanes", v, lane_disable)
    bus(1, 8'h00, 3, 0, 0);
    repeat (30) @(negedge ref_clk);
    `CMP("pending", 1'b1, init_pending)
    `CMP("lanes", 4'h0, lane_disable)
    bus(1, 8'h00, 1, 0, 0);
    repeat (300) @(posedge ref_clk);
    `CMP("pending", 1'b0, init_pending)
    seed = lfsr(seed);
    lane_fault <= seed[3:0];
    @(posedge ref_clk);
    lane_fault <= 4'h0;
    cmd(32'h10300);
    bus(0, 8'h08, 0, {16'h0, seed[3:0], 4'h1, 8'h00}, 32'hff00);
    $display("reset test done");
    conclude();
  end
endmodule : module_low_speed_control_tb
